// [rtl/dcsi_consts.svh]
/*
 Offsets, field positions, reset values and timing counts of the
 dual channel safe input block. Assumes a 40 MHz clock.
*/
//
// Summary of operation
// - three input pairs and one failsafe output
// - each input pair built from two channels
// - output has high, low switch plus readback
// - latched discrepancy fault freezes both channel states at zero
// - unresolved mismatch past window raises latched fault
// - one discrepancy window shared by all pairs
// - acknowledge by reset or falling edge plus confirm
// - release via chosen ack pair or extended ack
// - per pair break/break or break/make selection
// - break/break selects when both channels low
// - break/make selects on channel1 low, channel2 high
// - status word per channel, pair status ANDed
// - adjustable filter suppresses test and noise pulses
// - no test stop dynamisation of inputs
`ifndef DCSI_CONSTS_SVH
`define DCSI_CONSTS_SVH

`define DCSI_NUM_PAIRS 3
`define DCSI_CLK_PERIOD_NS 25
`define DCSI_TICK_NS 1000000
`define DCSI_TICK_CYCLES (`DCSI_TICK_NS / `DCSI_CLK_PERIOD_NS)

`define DCSI_OFF_CTRL 5'h00
`define DCSI_OFF_DISC 5'h04
`define DCSI_OFF_DEB 5'h08
`define DCSI_OFF_STATUS 5'h0C
`define DCSI_OFF_IRQ_STAT 5'h10
`define DCSI_OFF_IRQ_MASK 5'h14

`define DCSI_CTRL_MODE_LSB 0
`define DCSI_CTRL_SEL_LSB 4
`define DCSI_CTRL_ACK_BIT 8
`define DCSI_CTRL_EXT_ACK_BIT 9
`define DCSI_CTRL_POS_BIT 12
`define DCSI_CTRL_GND_BIT 13

`define DCSI_ST_CHAN_LSB 0
`define DCSI_ST_PAIR_LSB 8
`define DCSI_ST_FAULT_LSB 12
`define DCSI_ST_RDBK_BIT 16
`define DCSI_ST_ARMED_BIT 17

`define DCSI_IRQ_ACK_BIT 3

`define DCSI_RST_DISC 8'h0A
`define DCSI_RST_DEB 8'h01

`endif

// [rtl/dcsi_pkg.sv]
/*
 Types of the dual channel safe input block.
 Assumes the constants header for the pair count.
*/
`default_nettype none
`include "dcsi_consts.svh"
package dcsi_pkg;
   typedef enum logic [1:0] {
      DCSI_ACK_IDLE = 2'b00,
      DCSI_ACK_ARMED = 2'b01
   } dcsi_ack_t;
   typedef logic [7:0] dcsi_ticks_t;
   typedef logic [`DCSI_NUM_PAIRS-1:0] dcsi_pairs_t;
endpackage
`default_nettype wire

// [rtl/dcsi_flt_if.sv]
/*
 Link between the top module and one channel filter.
 Assumes one instance per channel.
*/
`timescale 1ns/1ps
`default_nettype none
interface dcsi_flt_if;
   logic raw;
   logic tick;
   dcsi_pkg::dcsi_ticks_t limit;
   logic filt;
   modport ctl (output raw, output tick, output limit, input filt);
   modport flt (input raw, input tick, input limit, output filt);
endinterface
`default_nettype wire

// [rtl/dcsi_filter.sv]
/*
 Input filter for one channel: a new level is accepted only after it
 has stood for the set number of ticks. Assumes a synchronous input.
*/
`timescale 1ns/1ps
`default_nettype none
module dcsi_filter (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // link to the top
   dcsi_flt_if.flt port_if
);
   logic filt;
   logic next_filt;
   dcsi_pkg::dcsi_ticks_t cnt;
   dcsi_pkg::dcsi_ticks_t next_cnt;

   // short pulses never reach the count, so they are suppressed
   always_comb begin
      next_filt = filt;
      next_cnt = cnt;
      if (port_if.raw == filt) begin
         next_cnt = 8'h00;
      end else if (cnt >= port_if.limit) begin
         next_filt = port_if.raw;
         next_cnt = 8'h00;
      end else if (port_if.tick) begin
         next_cnt = cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         filt <= 1'b0;
         cnt <= 8'h00;
      end else begin
         filt <= next_filt;
         cnt <= next_cnt;
      end
   end

   assign port_if.filt = filt;
endmodule
`default_nettype wire

// [rtl/dcsi_top.sv]
/*
 Dual channel safe input block: three filtered input pairs with
 contact mode, discrepancy watch, freeze and acknowledgment, one
 failsafe output with readback, Avalon-MM register slave, interrupt.
 Assumes inputs synchronous to clk and a master honouring waitrequest.
*/
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dcsi_consts.svh"
module dcsi_top #(
   parameter int TICK_CYCLES = `DCSI_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // input pairs
   input wire logic [`DCSI_NUM_PAIRS-1:0] ch1_in,
   input wire logic [`DCSI_NUM_PAIRS-1:0] ch2_in,
   // failsafe output
   output logic out_pos,
   output logic out_gnd,
   input wire logic out_readback,
   // interrupt
   output logic irq
);
   localparam int NP = `DCSI_NUM_PAIRS;

   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] wd,
                                         input logic en);
      merge8 = en ? wd : old;
   endfunction

   // tick
   logic [15:0] tick_cnt;
   logic [15:0] next_tick_cnt;
   logic tick;
   logic next_tick;

   always_comb begin
      next_tick = 1'b0;
      next_tick_cnt = tick_cnt + 16'h0001;
      if (tick_cnt >= 16'(TICK_CYCLES - 1)) begin
         next_tick_cnt = 16'h0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
      end
   end

   // registers
   dcsi_pkg::dcsi_pairs_t contact_mode;
   dcsi_pkg::dcsi_pairs_t next_contact_mode;
   logic [1:0] ack_input_select;
   logic [1:0] next_ack_input_select;
   dcsi_pkg::dcsi_ticks_t discrepancy_time_setting;
   dcsi_pkg::dcsi_ticks_t next_discrepancy_time_setting;
   dcsi_pkg::dcsi_ticks_t input_debounce_time;
   dcsi_pkg::dcsi_ticks_t next_input_debounce_time;
   logic out_pos_req;
   logic next_out_pos_req;
   logic out_gnd_req;
   logic next_out_gnd_req;
   logic [3:0] irq_stat;
   logic [3:0] next_irq_stat;
   logic [3:0] irq_mask;
   logic [3:0] next_irq_mask;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic wait_q;
   logic next_wait_q;
   logic irq_q;
   logic next_irq_q;
   logic readback_q;

   // evaluation state
   dcsi_pkg::dcsi_pairs_t discrepancy_fault;
   dcsi_pkg::dcsi_pairs_t next_discrepancy_fault;
   dcsi_pkg::dcsi_ticks_t disc_cnt [NP];
   dcsi_pkg::dcsi_ticks_t next_disc_cnt [NP];
   dcsi_pkg::dcsi_ack_t ack_state;
   dcsi_pkg::dcsi_ack_t next_ack_state;
   logic ack_prev;
   logic next_ack_prev;

   // filters, one per channel, ahead of all evaluation
   logic [NP-1:0] f1;
   logic [NP-1:0] f2;
   dcsi_flt_if flt_if [2*NP] ();

   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_pair
         assign flt_if[2*g].raw = ch1_in[g];
         assign flt_if[2*g+1].raw = ch2_in[g];
         assign flt_if[2*g].tick = tick;
         assign flt_if[2*g+1].tick = tick;
         assign flt_if[2*g].limit = input_debounce_time;
         assign flt_if[2*g+1].limit = input_debounce_time;
         assign f1[g] = flt_if[2*g].filt;
         assign f2[g] = flt_if[2*g+1].filt;
         dcsi_filter u_flt1 (.clk(clk), .nrst(nrst), .port_if(flt_if[2*g]));
         dcsi_filter u_flt2 (.clk(clk), .nrst(nrst), .port_if(flt_if[2*g+1]));
      end
   endgenerate

   // pair interpretation; filtered levels only, no test stop pulsing
   logic [NP-1:0] consistent;
   logic [NP-1:0] pair_status;
   logic [2*NP-1:0] status_word;
   always_comb begin
      for (int i = 0; i < NP; i++) begin
         // break/make expects channel 2 inverted
         consistent[i] = contact_mode[i] ? (f1[i] != f2[i]) : (f1[i] == f2[i]);
         if (discrepancy_fault[i]) begin
            status_word[2*i] = 1'b0;
            status_word[2*i+1] = 1'b0;
            pair_status[i] = 1'b0;
         end else begin
            status_word[2*i] = f1[i];
            status_word[2*i+1] = f2[i];
            // zero means safety function selected
            pair_status[i] = contact_mode[i] ? (f1[i] & ~f2[i])
                                             : (f1[i] & f2[i]);
         end
      end
   end

   // bus decode
   logic bus_req;
   logic wr_now;
   logic ack_cmd;
   logic ext_ack_cmd;
   assign bus_req = avs_read | avs_write;
   assign wr_now = avs_write & ~wait_q;
   assign ack_cmd = wr_now && avs_address == `DCSI_OFF_CTRL && avs_byteenable[1]
                    && avs_writedata[`DCSI_CTRL_ACK_BIT];
   assign ext_ack_cmd = wr_now && avs_address == `DCSI_OFF_CTRL && avs_byteenable[1]
                        && avs_writedata[`DCSI_CTRL_EXT_ACK_BIT];

   // acknowledgment sequence
   logic ack_src;
   logic ack_clear;
   always_comb begin
      ack_src = 1'b0;
      if (ack_input_select != 2'h0) begin
         ack_src = pair_status[ack_input_select - 2'h1];
      end
      next_ack_prev = ack_src;
      next_ack_state = ack_state;
      ack_clear = ext_ack_cmd;
      unique case (ack_state)
         dcsi_pkg::DCSI_ACK_IDLE: begin
            if (ack_input_select != 2'h0 && ack_prev && !ack_src) begin
               next_ack_state = dcsi_pkg::DCSI_ACK_ARMED;
            end
         end
         dcsi_pkg::DCSI_ACK_ARMED: begin
            if (ack_cmd) begin
               ack_clear = 1'b1;
               next_ack_state = dcsi_pkg::DCSI_ACK_IDLE;
            end
         end
         default: next_ack_state = dcsi_pkg::DCSI_ACK_IDLE;
      endcase
      if (ext_ack_cmd) begin
         next_ack_state = dcsi_pkg::DCSI_ACK_IDLE;
      end
   end

   // discrepancy watch with one shared window
   logic [NP-1:0] fault_set;
   always_comb begin
      for (int i = 0; i < NP; i++) begin
         next_disc_cnt[i] = disc_cnt[i];
         fault_set[i] = 1'b0;
         if (consistent[i]) begin
            next_disc_cnt[i] = 8'h00;
         end else if (disc_cnt[i] >= discrepancy_time_setting) begin
            fault_set[i] = ~discrepancy_fault[i];
         end else if (tick) begin
            next_disc_cnt[i] = disc_cnt[i] + 8'h01;
         end
      end
      // a new fault wins over a simultaneous acknowledgment
      next_discrepancy_fault = (discrepancy_fault & ~{NP{ack_clear}}) | fault_set;
   end

   // register file and bus answer
   always_comb begin
      next_contact_mode = contact_mode;
      next_ack_input_select = ack_input_select;
      next_discrepancy_time_setting = discrepancy_time_setting;
      next_input_debounce_time = input_debounce_time;
      next_out_pos_req = out_pos_req;
      next_out_gnd_req = out_gnd_req;
      next_irq_mask = irq_mask;
      next_rdata = rdata;
      next_wait_q = 1'b1;
      next_irq_stat = irq_stat;
      if (bus_req && wait_q) begin
         next_wait_q = 1'b0;
         next_rdata = 32'h0000_0000;
         unique case (avs_address)
            `DCSI_OFF_CTRL: begin
               next_rdata[`DCSI_CTRL_MODE_LSB +: NP] = contact_mode;
               next_rdata[`DCSI_CTRL_SEL_LSB +: 2] = ack_input_select;
               next_rdata[`DCSI_CTRL_POS_BIT] = out_pos_req;
               next_rdata[`DCSI_CTRL_GND_BIT] = out_gnd_req;
            end
            `DCSI_OFF_DISC: next_rdata[7:0] = discrepancy_time_setting;
            `DCSI_OFF_DEB: next_rdata[7:0] = input_debounce_time;
            `DCSI_OFF_STATUS: begin
               next_rdata[`DCSI_ST_CHAN_LSB +: 2*NP] = status_word;
               next_rdata[`DCSI_ST_PAIR_LSB +: NP] = pair_status;
               next_rdata[`DCSI_ST_FAULT_LSB +: NP] = discrepancy_fault;
               next_rdata[`DCSI_ST_RDBK_BIT] = readback_q;
               next_rdata[`DCSI_ST_ARMED_BIT] = (ack_state == dcsi_pkg::DCSI_ACK_ARMED);
            end
            `DCSI_OFF_IRQ_STAT: next_rdata[3:0] = irq_stat;
            `DCSI_OFF_IRQ_MASK: next_rdata[3:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
      if (wr_now) begin
         unique case (avs_address)
            `DCSI_OFF_CTRL: begin
               if (avs_byteenable[0]) begin
                  next_contact_mode = avs_writedata[`DCSI_CTRL_MODE_LSB +: NP];
                  next_ack_input_select = avs_writedata[`DCSI_CTRL_SEL_LSB +: 2];
               end
               if (avs_byteenable[1]) begin
                  next_out_pos_req = avs_writedata[`DCSI_CTRL_POS_BIT];
                  next_out_gnd_req = avs_writedata[`DCSI_CTRL_GND_BIT];
               end
            end
            `DCSI_OFF_DISC: next_discrepancy_time_setting =
               merge8(discrepancy_time_setting, avs_writedata[7:0], avs_byteenable[0]);
            `DCSI_OFF_DEB: next_input_debounce_time =
               merge8(input_debounce_time, avs_writedata[7:0], avs_byteenable[0]);
            `DCSI_OFF_IRQ_STAT: begin
               if (avs_byteenable[0]) begin
                  next_irq_stat = irq_stat & ~avs_writedata[3:0];
               end
            end
            `DCSI_OFF_IRQ_MASK: begin
               if (avs_byteenable[0]) begin
                  next_irq_mask = avs_writedata[3:0];
               end
            end
            default: next_irq_mask = irq_mask;
         endcase
      end
      // events set after the clear so a coincident event survives
      next_irq_stat[NP-1:0] = next_irq_stat[NP-1:0] | fault_set;
      next_irq_stat[`DCSI_IRQ_ACK_BIT] = next_irq_stat[`DCSI_IRQ_ACK_BIT]
                                         | (ack_clear & |discrepancy_fault);
      next_irq_q = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         contact_mode <= '0;
         ack_input_select <= 2'h0;
         discrepancy_time_setting <= `DCSI_RST_DISC;
         input_debounce_time <= `DCSI_RST_DEB;
         out_pos_req <= 1'b0;
         out_gnd_req <= 1'b0;
         irq_stat <= 4'h0;
         irq_mask <= 4'h0;
         rdata <= 32'h0000_0000;
         wait_q <= 1'b1;
         irq_q <= 1'b0;
         readback_q <= 1'b0;
         discrepancy_fault <= '0;
         ack_state <= dcsi_pkg::DCSI_ACK_IDLE;
         ack_prev <= 1'b0;
         for (int i = 0; i < NP; i++) begin
            disc_cnt[i] <= 8'h00;
         end
      end else begin
         contact_mode <= next_contact_mode;
         ack_input_select <= next_ack_input_select;
         discrepancy_time_setting <= next_discrepancy_time_setting;
         input_debounce_time <= next_input_debounce_time;
         out_pos_req <= next_out_pos_req;
         out_gnd_req <= next_out_gnd_req;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         rdata <= next_rdata;
         wait_q <= next_wait_q;
         irq_q <= next_irq_q;
         readback_q <= out_readback;
         discrepancy_fault <= next_discrepancy_fault;
         ack_state <= next_ack_state;
         ack_prev <= next_ack_prev;
         for (int i = 0; i < NP; i++) begin
            disc_cnt[i] <= next_disc_cnt[i];
         end
      end
   end

   // one failsafe output, both switches from registers
   assign out_pos = out_pos_req;
   assign out_gnd = out_gnd_req;
   assign avs_readdata = rdata;
   assign avs_waitrequest = wait_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// [testbench/dcsi_checker.sv]
/*
 Checker of the safe input block: bus timing, status and output relations.
 Assumes the ports of dcsi_top and the constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcsi_consts.svh"
module dcsi_checker #(
   parameter int TICK_CYCLES = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // pairs, output, interrupt
   input wire logic [`DCSI_NUM_PAIRS-1:0] ch1_in,
   input wire logic [`DCSI_NUM_PAIRS-1:0] ch2_in,
   input wire logic out_pos,
   input wire logic out_gnd,
   input wire logic out_readback,
   input wire logic irq
);
   logic [2:0] mode;
   logic [2:0] next_mode;
   logic [2:0] exp_pair;
   logic [2:0] frz_ok;
   logic rd_st;
   logic wr_ctrl;
   assign rd_st = avs_read && !avs_waitrequest && avs_address == `DCSI_OFF_STATUS;
   assign wr_ctrl = avs_write && !avs_waitrequest && avs_address == `DCSI_OFF_CTRL;
   // contact mode as last written
   always_comb begin
      next_mode = mode;
      if (wr_ctrl && avs_byteenable[0]) begin
         next_mode = avs_writedata[2:0];
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode <= 3'h0;
      end else begin
         mode <= next_mode;
      end
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         exp_pair[i] = avs_readdata[2*i] & (avs_readdata[2*i+1] ^ mode[i]);
         frz_ok[i] = !avs_readdata[12+i] || (avs_readdata[2*i+:2] == 2'b00);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait state");
   wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest
      && avs_address > `DCSI_OFF_IRQ_MASK |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   ack_reads_zero_a: assert property (avs_read && !avs_waitrequest
      && avs_address == `DCSI_OFF_CTRL |-> avs_readdata[9:8] == 2'h0)
      else $error("acknowledge bits read back");
   freeze_zero_a: assert property (rd_st |-> frz_ok == 3'h7
      && (avs_readdata[14:12] & avs_readdata[10:8]) == 3'h0)
      else $error("faulted pair not frozen at zero");
   pair_and_a: assert property (rd_st |-> avs_readdata[10:8] == exp_pair)
      else $error("pair status not combined from channels");
   out_follow_a: assert property (wr_ctrl && avs_byteenable[1] |=>
      out_pos == $past(avs_writedata[12]) && out_gnd == $past(avs_writedata[13]))
      else $error("switch outputs do not follow control");
   irq_masked_a: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
      && avs_address == `DCSI_OFF_IRQ_MASK && avs_writedata[3:0] == 4'h0 |=> ##1 !irq)
      else $error("interrupt high with all sources masked");
endmodule
`default_nettype wire

// [testbench/dcsi_sensor.sv]
/*
 Sensor model: three two-channel contacts and a load reading back the
 failsafe output. Assumes commands from the bench at clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dcsi_sensor (
   // clock
   input wire logic clk,
   // commands
   input wire logic [2:0] sel,
   input wire logic [2:0] mode,
   input wire logic [2:0] stuck,
   // failsafe output
   input wire logic out_pos,
   input wire logic out_gnd,
   // contacts and readback
   output logic [2:0] ch1 = 3'h7,
   output logic [2:0] ch2 = 3'h7,
   output logic readback = 1'b0
);
   // contacts open to select, channel 2 closes instead in break/make; a stuck second contact keeps its level
   always @(posedge clk) begin
      ch1 <= ~sel;
      ch2 <= (stuck & ch2) | (~stuck & (sel ^ ~mode));
      readback <= out_pos & out_gnd;
   end
endmodule
`default_nettype wire

// [testbench/test_dual_channel_safe_input.sv]
/*
 Bench of the safe input block: random contact patterns, filter, fault,
 freeze, acknowledgment, interrupt, outputs. Assumes top, checker, sensor.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcsi_consts.svh"
module test_dual_channel_safe_input;
   localparam int TK = 4;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [2:0] ch1_in;
   logic [2:0] ch2_in;
   logic out_pos;
   logic out_gnd;
   logic out_readback;
   logic irq;
   logic [2:0] sel = 3'h0;
   logic [2:0] mode = 3'h0;
   logic [2:0] stuck = 3'h0;
   logic [31:0] rd;
   logic [31:0] r;
   integer seed = 32'hef51;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   always #12.5 clk = ~clk;
   dcsi_top #(.TICK_CYCLES(TK)) u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .ch1_in(ch1_in), .ch2_in(ch2_in), .out_pos(out_pos), .out_gnd(out_gnd),
      .out_readback(out_readback), .irq(irq));
   dcsi_sensor u_sensor (.clk(clk), .sel(sel), .mode(mode), .stuck(stuck), .out_pos(out_pos),
      .out_gnd(out_gnd), .ch1(ch1_in), .ch2(ch2_in), .readback(out_readback));
   task automatic finish_test;
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   // one bus transfer, held until waitrequest is seen low
   task automatic bus(input int wr, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= (wr != 0);
      avs_read <= (wr == 0);
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ticks(input int n);
      repeat (n * TK) @(posedge clk);
   endtask
   function automatic logic [31:0] exp_st(input logic [2:0] s, input logic [2:0] m);
      exp_st = 32'h0;
      for (int i = 0; i < 3; i++) begin
         exp_st[2*i] = ~s[i];
         exp_st[2*i+1] = s[i] ^ ~m[i];
         exp_st[8+i] = ~s[i];
      end
   endfunction
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         finish_test;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      bus(0, `DCSI_OFF_DISC, 0);
      chk("disc reset", {24'h0, `DCSI_RST_DISC}, rd);
      bus(0, `DCSI_OFF_DEB, 0);
      chk("deb reset", {24'h0, `DCSI_RST_DEB}, rd);
      bus(1, 5'h18, 32'hFFFFFFFF);
      bus(0, 5'h18, 0);
      chk("unmapped", 32'h0, rd);
      bus(1, `DCSI_OFF_DISC, 32'h4);
      // byte lane 0 disabled: the window must keep its value
      avs_byteenable <= 4'hE;
      bus(1, `DCSI_OFF_DISC, 32'h33);
      avs_byteenable <= 4'hF;
      bus(0, `DCSI_OFF_DISC, 0);
      chk("disc lane", 32'h4, rd);
      for (int n = 0; n < 12; n++) begin
         r = $random(seed);
         if (n < 2) begin
            r = n ? 32'h77 : 32'h0;
         end
         bus(1, `DCSI_OFF_CTRL, {28'h0, 1'b0, r[6:4]});
         mode <= r[6:4];
         sel <= r[2:0];
         ticks(4);
         bus(0, `DCSI_OFF_STATUS, 0);
         chk("status", exp_st(r[2:0], r[6:4]), rd);
      end
      bus(1, `DCSI_OFF_CTRL, 0);
      mode <= 3'h0;
      sel <= 3'h0;
      bus(1, `DCSI_OFF_DEB, 32'h2);
      ticks(4);
      sel <= 3'h7;
      repeat (3) @(posedge clk);
      sel <= 3'h0;
      // read while the pulse would still show if it were passed
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("glitch", exp_st(3'h0, 3'h0), rd);
      bus(1, `DCSI_OFF_DEB, 32'h1);
      bus(1, `DCSI_OFF_IRQ_MASK, 32'hF);
      stuck <= 3'h1;
      sel <= 3'h1;
      ticks(2);
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("early fault", 32'h0, rd & 32'h7000);
      ticks(6);
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("fault", exp_st(3'h1, 3'h0) | 32'h1000, rd);
      bus(0, `DCSI_OFF_IRQ_STAT, 0);
      chk("irq stat", 32'h1, rd);
      chk("irq", 32'h1, {31'h0, irq});
      stuck <= 3'h0;
      sel <= 3'h0;
      ticks(4);
      bus(1, `DCSI_OFF_CTRL, 32'h100);
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("frozen", (exp_st(3'h0, 3'h0) & ~32'h103) | 32'h1000, rd);
      bus(1, `DCSI_OFF_CTRL, 32'h20);
      sel <= 3'h2;
      ticks(3);
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("armed", 32'h20000, rd & 32'h20000);
      bus(1, `DCSI_OFF_CTRL, 32'h120);
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("acked", exp_st(3'h2, 3'h0), rd);
      bus(0, `DCSI_OFF_CTRL, 0);
      chk("ctrl", 32'h20, rd);
      bus(0, `DCSI_OFF_IRQ_STAT, 0);
      chk("ack event", 32'h9, rd);
      bus(1, `DCSI_OFF_IRQ_STAT, 32'hF);
      bus(0, `DCSI_OFF_IRQ_STAT, 0);
      chk("w1c", 32'h0, rd);
      chk("irq clear", 32'h0, {31'h0, irq});
      bus(1, `DCSI_OFF_CTRL, 32'h0);
      stuck <= 3'h4;
      sel <= 3'h4;
      ticks(8);
      bus(1, `DCSI_OFF_IRQ_MASK, 32'h0);
      @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1, `DCSI_OFF_IRQ_MASK, 32'h4);
      @(posedge clk);
      chk("irq pair2", 32'h1, {31'h0, irq});
      stuck <= 3'h0;
      sel <= 3'h0;
      ticks(4);
      bus(1, `DCSI_OFF_CTRL, 32'h200);
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("ext ack", exp_st(3'h0, 3'h0), rd);
      for (int k = 0; k < 4; k++) begin
         bus(1, `DCSI_OFF_CTRL, k << 12);
         chk("switches", k, {30'h0, out_gnd, out_pos});
         repeat (2) @(posedge clk);
         bus(0, `DCSI_OFF_STATUS, 0);
         chk("readback", (k == 3) ? 32'h1 : 32'h0, {31'h0, rd[16]});
      end
      // fault again, then clear it by a reset in mid-run
      stuck <= 3'h1;
      sel <= 3'h1;
      ticks(8);
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("refault", 32'h1000, rd & 32'h7000);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk("reset out", 32'h0, {30'h0, out_gnd, out_pos});
      bus(0, `DCSI_OFF_STATUS, 0);
      chk("power on", 32'h0, rd & 32'h7000);
      finish_test;
   end
endmodule
bind dcsi_top dcsi_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .nrst(nrst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ch1_in(ch1_in),
   .ch2_in(ch2_in), .out_pos(out_pos), .out_gnd(out_gnd), .out_readback(out_readback),
   .irq(irq));
`default_nettype wire
